// ===== inc/cmla_params.svh
// constants for the math and logic execution unit
`ifndef CMLA_PARAMS_SVH
`define CMLA_PARAMS_SVH
`define CMLA_WIDTH       32
`define CMLA_ADDR_BITS   20
`define CMLA_FIELD_LO    4:0
`define CMLA_FIELD_SPAN  9:5
`define CMLA_OP_CYCLES   2
`define CMLA_RESULT_RST  32'h0000_0000
`define CMLA_POINTER_RST 32'h0000_0000
`define CMLA_CRC_BITS    4
`endif

// ===== inc/cmla_pkg.sv
// operation codes and pointer-select types for the math and logic execution unit
package cmla_pkg;
  typedef enum logic [5:0] {
    CMLA_MAGNITUDE_OP, CMLA_SUM_OP, CMLA_SIGNED_SUM_OP, CMLA_EXTENDED_SUM_OP,
    CMLA_SIGNED_EXTENDED_SUM_OP, CMLA_MASK_KEEP_OP, CMLA_MASK_CLEAR_OP,
    CMLA_FIELD_FROM_CARRY, CMLA_FIELD_SET_HIGH, CMLA_FIELD_SET_LOW,
    CMLA_FIELD_FROM_INV_CARRY, CMLA_FIELD_TOGGLE, CMLA_FIELD_FROM_INV_ZERO,
    CMLA_FIELD_RANDOM, CMLA_FIELD_FROM_ZERO, CMLA_LOW_MASK_GEN, CMLA_COMPARE_OP,
    CMLA_COMPARE_MSB_OP, CMLA_COMPARE_REVERSE_OP, CMLA_COMPARE_SIGNED_OP,
    CMLA_CONDITIONAL_SUBTRACT_OP, CMLA_COMPARE_SIGNED_EXTENDED_OP,
    CMLA_COMPARE_EXTENDED_OP, CMLA_CRC_BIT_STEP, CMLA_CRC_NIBBLE_STEP,
    CMLA_WRAP_DECREMENT, CMLA_WRAP_INCREMENT, CMLA_ONE_HOT_DECODE,
    CMLA_PRIORITY_ENCODE, CMLA_FORCE_MIN_OP, CMLA_FORCE_MIN_SIGNED_OP,
    CMLA_FORCE_MAX_OP, CMLA_FORCE_MAX_SIGNED_OP, CMLA_EXTRACT_BYTE,
    CMLA_EXTRACT_NIBBLE, CMLA_EXTRACT_WORD, CMLA_LOAD_ADDRESS_OP
  } cmla_op_t;
  typedef enum logic [1:0] {
    CMLA_GENERAL_POINTER_A, CMLA_GENERAL_POINTER_B, CMLA_HUB_INDEX_ONE, CMLA_HUB_INDEX_TWO
  } cmla_ptr_t;
endpackage

// ===== rtl/cmla_crc_step.sv
// one crc bit step, combinational
module cmla_crc_step (
  input  wire logic [31:0] crcIn,
  input  wire logic        bitIn,
  input  wire logic [31:0] poly,
  output logic      [31:0] crcOut
);
  always_comb begin
    if (bitIn ^ crcIn[0]) begin
      crcOut = (crcIn >> 1) ^ poly;
    end else begin
      crcOut = crcIn >> 1;
    end
  end
endmodule

// ===== rtl/cmla_math_logic_alu.sv
// two-cycle math and logic execution unit of one processor core
module cmla_math_logic_alu
  import cmla_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        clkEn,
  input  wire logic        opValid,
  input  wire cmla_op_t    opCode,
  input  wire logic [31:0] dstIn,
  input  wire logic [31:0] srcIn,
  input  wire logic        singleOperand,
  input  wire logic        carryIn,
  input  wire logic        zeroIn,
  input  wire logic        carryWriteFlag,
  input  wire logic        zeroWriteFlag,
  input  wire logic        queuePrefixSet,
  input  wire logic [31:0] queueIn,
  input  wire logic [31:0] randomBits,
  input  wire logic [1:0]  extractIndex,
  input  wire logic [31:0] programCounter,
  input  wire logic        relativeBit,
  input  wire logic        forceAbsolute,
  input  wire cmla_ptr_t   pointerSel,
  output logic             resultValid,
  output logic [31:0]      result,
  output logic             resultWrite,
  output logic             carryOut,
  output logic             zeroOut,
  output logic             carryWrite,
  output logic             zeroWrite,
  output logic [31:0]      queueOut,
  output logic             queueWrite,
  output logic             pointerWrite,
  output logic [1:0]       pointerIndex
);
  `include "cmla_params.svh"

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [32:0] addCarry(input logic [31:0] a, input logic [31:0] b,
                                           input logic ci);
    addCarry = {1'b0, a} + {1'b0, b} + {32'h0000_0000, ci};
  endfunction

  // difference with borrow in bit 32
  function automatic logic [32:0] subBorrow(input logic [31:0] a, input logic [31:0] b,
                                            input logic bi);
    subBorrow = {1'b0, a} - {1'b0, b} - {32'h0000_0000, bi};
  endfunction

  // true sign of a signed sum or difference: overflow flips the raw top bit
  function automatic logic trueSign(input logic a31, input logic b31, input logic r31,
                                    input logic isSub);
    logic ovf;
    ovf = isSub ? ((a31 != b31) && (r31 != a31)) : ((a31 == b31) && (r31 != a31));
    trueSign = r31 ^ ovf;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // stage one: capture operands
  logic        busy_q;
  cmla_op_t    op_q;
  logic [31:0] dst_q, src_q, queue_q, rnd_q, pc_q;
  logic        single_q, c_q, z_q, wc_q, wz_q, qset_q, rel_q, force_q;
  logic [1:0]  idx_q;
  cmla_ptr_t   ptr_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else if (clkEn) begin
      busy_q <= opValid;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      op_q     <= CMLA_MAGNITUDE_OP;
      dst_q    <= `CMLA_RESULT_RST;
      src_q    <= `CMLA_RESULT_RST;
      queue_q  <= `CMLA_RESULT_RST;
      rnd_q    <= `CMLA_RESULT_RST;
      pc_q     <= `CMLA_RESULT_RST;
      single_q <= 1'b0;
      c_q      <= 1'b0;
      z_q      <= 1'b0;
      wc_q     <= 1'b0;
      wz_q     <= 1'b0;
      qset_q   <= 1'b0;
      rel_q    <= 1'b0;
      force_q  <= 1'b0;
      idx_q    <= 2'h0;
      ptr_q    <= CMLA_GENERAL_POINTER_A;
    end else if (clkEn && opValid) begin
      op_q     <= opCode;
      dst_q    <= dstIn;
      src_q    <= srcIn;
      queue_q  <= queueIn;
      rnd_q    <= randomBits;
      pc_q     <= programCounter;
      single_q <= singleOperand;
      c_q      <= carryIn;
      z_q      <= zeroIn;
      wc_q     <= carryWriteFlag;
      wz_q     <= zeroWriteFlag;
      qset_q   <= queuePrefixSet;
      rel_q    <= relativeBit;
      force_q  <= forceAbsolute;
      idx_q    <= extractIndex;
      ptr_q    <= pointerSel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // crc chain: four bit steps fed from queue top, msb first, for the nibble step; from carry for other ops
  logic [31:0] crcChain [0:4];
  assign crcChain[0] = dst_q;
  genvar gi;
  generate
    for (gi = 0; gi < `CMLA_CRC_BITS; gi++) begin : g_crc
      cmla_crc_step u_step (
        .crcIn  (crcChain[gi]),
        .bitIn  (op_q == CMLA_CRC_NIBBLE_STEP ? queue_q[31 - gi] : c_q),
        .poly   (src_q),
        .crcOut (crcChain[gi + 1])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // stage two: compute
  logic [31:0] resD, fieldMask, oper, addrSum;
  logic        carD, zerD, zeroDefault, writeD;
  logic [32:0] sum, dif;
  logic [4:0]  lowIdx, span;
  logic [5:0]  hiIdx;

  always_comb begin
    oper    = single_q ? dst_q : src_q;
    resD    = dst_q;
    carD    = c_q;
    zeroDefault = 1'b1;
    zerD    = z_q;
    writeD  = 1'b1;
    sum     = 33'h0_0000_0000;
    dif     = 33'h0_0000_0000;
    addrSum = 32'h0000_0000;
    lowIdx  = src_q[`CMLA_FIELD_LO];
    span    = qset_q ? queue_q[4:0] : src_q[`CMLA_FIELD_SPAN];
    hiIdx   = {1'b0, lowIdx} + {1'b0, span};
    fieldMask = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (i >= lowIdx && i <= hiIdx) begin
        fieldMask[i] = 1'b1;
      end
    end
    unique case (op_q)
      CMLA_MAGNITUDE_OP: begin
        resD = oper[31] ? (~oper + 32'h0000_0001) : oper;
        carD = oper[31];
      end
      CMLA_SUM_OP: begin
        sum  = addCarry(dst_q, src_q, 1'b0);
        resD = sum[31:0];
        carD = sum[32];
      end
      CMLA_SIGNED_SUM_OP: begin
        sum  = addCarry(dst_q, src_q, 1'b0);
        resD = sum[31:0];
        carD = trueSign(dst_q[31], src_q[31], sum[31], 1'b0);
      end
      CMLA_EXTENDED_SUM_OP, CMLA_SIGNED_EXTENDED_SUM_OP: begin
        sum  = addCarry(dst_q, src_q, c_q);
        resD = sum[31:0];
        carD = (op_q == CMLA_EXTENDED_SUM_OP) ? sum[32]
             : trueSign(dst_q[31], src_q[31], sum[31], 1'b0);
        zeroDefault = 1'b0;
        zerD = z_q & (sum[31:0] == 32'h0000_0000);
      end
      CMLA_MASK_KEEP_OP, CMLA_MASK_CLEAR_OP: begin
        resD = dst_q & ((op_q == CMLA_MASK_KEEP_OP) ? src_q : ~src_q);
        carD = ^resD;
      end
      CMLA_FIELD_FROM_CARRY, CMLA_FIELD_SET_HIGH, CMLA_FIELD_SET_LOW,
      CMLA_FIELD_FROM_INV_CARRY, CMLA_FIELD_TOGGLE, CMLA_FIELD_FROM_INV_ZERO,
      CMLA_FIELD_RANDOM, CMLA_FIELD_FROM_ZERO: begin
        unique case (op_q)
          CMLA_FIELD_FROM_CARRY:     resD = (dst_q & ~fieldMask) | (fieldMask & {32{c_q}});
          CMLA_FIELD_SET_HIGH:       resD = dst_q | fieldMask;
          CMLA_FIELD_SET_LOW:        resD = dst_q & ~fieldMask;
          CMLA_FIELD_FROM_INV_CARRY: resD = (dst_q & ~fieldMask) | (fieldMask & {32{~c_q}});
          CMLA_FIELD_TOGGLE:         resD = dst_q ^ fieldMask;
          CMLA_FIELD_FROM_INV_ZERO:  resD = (dst_q & ~fieldMask) | (fieldMask & {32{~z_q}});
          CMLA_FIELD_RANDOM:         resD = (dst_q & ~fieldMask) | (fieldMask & rnd_q);
          default:                   resD = (dst_q & ~fieldMask) | (fieldMask & {32{z_q}});
        endcase
        carD = dst_q[lowIdx];
        zeroDefault = 1'b0;
        zerD = dst_q[lowIdx];
      end
      CMLA_LOW_MASK_GEN: begin
        resD = (32'h0000_0002 << oper[4:0]) - 32'h0000_0001;
      end
      CMLA_COMPARE_OP, CMLA_COMPARE_MSB_OP, CMLA_COMPARE_SIGNED_OP: begin
        writeD = 1'b0;
        dif  = subBorrow(dst_q, src_q, 1'b0);
        carD = (op_q == CMLA_COMPARE_OP) ? dif[32]
             : (op_q == CMLA_COMPARE_MSB_OP) ? dif[31]
             : trueSign(dst_q[31], src_q[31], dif[31], 1'b1);
        zeroDefault = 1'b0;
        zerD = (dst_q == src_q);
      end
      CMLA_COMPARE_REVERSE_OP: begin
        writeD = 1'b0;
        dif  = subBorrow(src_q, dst_q, 1'b0);
        carD = dif[32];
        zeroDefault = 1'b0;
        zerD = (dst_q == src_q);
      end
      CMLA_COMPARE_EXTENDED_OP, CMLA_COMPARE_SIGNED_EXTENDED_OP: begin
        writeD = 1'b0;
        dif  = subBorrow(dst_q, src_q, c_q);
        carD = (op_q == CMLA_COMPARE_EXTENDED_OP) ? dif[32]
             : trueSign(dst_q[31], src_q[31], dif[31], 1'b1);
        zeroDefault = 1'b0;
        zerD = z_q & (dif[31:0] == 32'h0000_0000);
      end
      CMLA_CONDITIONAL_SUBTRACT_OP: begin
        dif  = subBorrow(dst_q, src_q, 1'b0);
        carD = ~dif[32];
        resD = dif[32] ? dst_q : dif[31:0];
      end
      CMLA_CRC_BIT_STEP: begin
        resD = crcChain[1];
      end
      CMLA_CRC_NIBBLE_STEP: begin
        resD = crcChain[4];
      end
      CMLA_WRAP_DECREMENT: begin
        carD = (dst_q == 32'h0000_0000);
        resD = carD ? src_q : dst_q - 32'h0000_0001;
      end
      CMLA_WRAP_INCREMENT: begin
        carD = (dst_q == src_q);
        resD = carD ? 32'h0000_0000 : dst_q + 32'h0000_0001;
      end
      CMLA_ONE_HOT_DECODE: begin
        resD = 32'h0000_0001 << oper[4:0];
      end
      CMLA_PRIORITY_ENCODE: begin
        resD = 32'h0000_0000;
        for (int i = 0; i < 32; i++) begin
          if (oper[i]) begin
            resD = 32'(i);
          end
        end
        carD = (oper != 32'h0000_0000);
      end
      CMLA_FORCE_MIN_OP, CMLA_FORCE_MIN_SIGNED_OP: begin
        carD = (op_q == CMLA_FORCE_MIN_OP) ? (dst_q < src_q)
             : ($signed(dst_q) < $signed(src_q));
        resD = carD ? src_q : dst_q;
      end
      CMLA_FORCE_MAX_OP, CMLA_FORCE_MAX_SIGNED_OP: begin
        carD = (op_q == CMLA_FORCE_MAX_OP) ? (dst_q > src_q)
             : ($signed(dst_q) > $signed(src_q));
        resD = carD ? src_q : dst_q;
      end
      CMLA_EXTRACT_BYTE: begin
        resD = {24'h00_0000, src_q[8 * idx_q +: 8]};
      end
      CMLA_EXTRACT_NIBBLE: begin
        resD = {28'h000_0000, src_q[4 * {1'b0, idx_q} +: 4]};
      end
      CMLA_EXTRACT_WORD: begin
        resD = {16'h0000, src_q[16 * idx_q[0] +: 16]};
      end
      CMLA_LOAD_ADDRESS_OP: begin
        addrSum = (rel_q && !force_q) ? pc_q + src_q : src_q;
        resD = {12'h000, addrSum[`CMLA_ADDR_BITS-1:0]};
      end
    endcase
    if (zeroDefault) begin
      zerD = (resD == 32'h0000_0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // result registers, valid on the next enabled clock after the op is taken
  always_ff @(posedge mclk) begin
    if (srst) begin
      resultValid  <= 1'b0;
      result       <= `CMLA_RESULT_RST;
      resultWrite  <= 1'b0;
      carryOut     <= 1'b0;
      zeroOut      <= 1'b0;
      carryWrite   <= 1'b0;
      zeroWrite    <= 1'b0;
      queueOut     <= `CMLA_RESULT_RST;
      queueWrite   <= 1'b0;
      pointerWrite <= 1'b0;
      pointerIndex <= 2'h0;
    end else if (clkEn) begin
      resultValid  <= busy_q;
      result       <= resD;
      resultWrite  <= busy_q && writeD && (op_q != CMLA_LOAD_ADDRESS_OP);
      carryOut     <= carD;
      zeroOut      <= zerD;
      carryWrite   <= busy_q && wc_q;
      zeroWrite    <= busy_q && wz_q;
      queueOut     <= queue_q << 4;
      queueWrite   <= busy_q && (op_q == CMLA_CRC_NIBBLE_STEP);
      pointerWrite <= busy_q && (op_q == CMLA_LOAD_ADDRESS_OP);
      pointerIndex <= ptr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  a_two_clock_latency: assert property (@(posedge mclk) disable iff (srst)
    (clkEn && opValid) ##1 clkEn |=> resultValid)
    else $error("result not valid two clocks after op");
  a_flag_write_gate: assert property (@(posedge mclk) disable iff (srst)
    $past(clkEn) && carryWrite |-> $past(wc_q) && $past(busy_q))
    else $error("carry written without select");
  a_compare_no_write: assert property (@(posedge mclk) disable iff (srst)
    (clkEn && busy_q && op_q == CMLA_COMPARE_OP) |=> !resultWrite)
    else $error("compare wrote destination");
  a_sum_carry_out: assert property (@(posedge mclk) disable iff (srst)
    (clkEn && busy_q && op_q == CMLA_SUM_OP)
      |=> {carryOut, result} == {1'b0, $past(dst_q)} + {1'b0, $past(src_q)})
    else $error("sum or carry wrong");
  a_condsub_carry: assert property (@(posedge mclk) disable iff (srst)
    (clkEn && busy_q && op_q == CMLA_CONDITIONAL_SUBTRACT_OP)
      |=> carryOut == ($past(dst_q) >= $past(src_q)))
    else $error("conditional subtract carry wrong");
  a_decode_one_hot: assert property (@(posedge mclk) disable iff (srst)
    (clkEn && busy_q && op_q == CMLA_ONE_HOT_DECODE) |=> $onehot(result))
    else $error("decode not one hot");
  a_wrap_inc_zero: assert property (@(posedge mclk) disable iff (srst)
    (clkEn && busy_q && op_q == CMLA_WRAP_INCREMENT && dst_q == src_q)
      |=> carryOut && result == 32'h0000_0000)
    else $error("wrap increment did not wrap");
  a_mask_parity: assert property (@(posedge mclk) disable iff (srst)
    (clkEn && busy_q && op_q == CMLA_MASK_KEEP_OP) |=> carryOut == ^result)
    else $error("mask parity wrong");
  a_address_width: assert property (@(posedge mclk) disable iff (srst)
    pointerWrite |-> result[31:20] == 12'h000)
    else $error("address not zero extended");
endmodule

// ===== verif/cmla_core_model.sv
// core-side model: the flag registers that feed carry and zero back into the unit
module cmla_core_model (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic presetEn,
  input  wire logic presetCarry,
  input  wire logic presetZero,
  input  wire logic carryWrite,
  input  wire logic zeroWrite,
  input  wire logic carryOut,
  input  wire logic zeroOut,
  output logic      flagCarry,
  output logic      flagZero
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flagCarry_q;
  logic flagZero_q;
  // flags change only on reset, a preset or a write pulse, so a stray pulse shows up in the next op
  always_ff @(posedge mclk) begin
    if (srst) begin
      flagCarry_q <= 1'h0;
      flagZero_q  <= 1'h0;
    end else if (presetEn) begin
      flagCarry_q <= presetCarry;
      flagZero_q  <= presetZero;
    end else begin
      if (carryWrite) flagCarry_q <= carryOut;
      if (zeroWrite) flagZero_q <= zeroOut;
    end
  end
  assign flagCarry = flagCarry_q;
  assign flagZero  = flagZero_q;
endmodule

// ===== verif/cog_math_logic_alu_tb.sv
// self-checking bench for the math and logic execution unit
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (b)); end end
module cog_math_logic_alu_tb;
  import cmla_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0, srst = 1'h1, clkEn = 1'h1, opValid = 1'h0, singleOperand = 1'h0;
  cmla_op_t opCode = CMLA_SUM_OP;
  cmla_ptr_t pointerSel = CMLA_GENERAL_POINTER_A;
  logic [31:0] dstIn = '0, srcIn = '0, queueIn = '0, randomBits = '0, programCounter = '0;
  logic carryWriteFlag = 1'h0, zeroWriteFlag = 1'h0, queuePrefixSet = 1'h0, relativeBit = 1'h0;
  logic forceAbsolute = 1'h0, presetEn = 1'h0, presetCarry = 1'h0, presetZero = 1'h0;
  logic [1:0] extractIndex = 2'h0, pointerIndex;
  logic carryIn, zeroIn, resultValid, resultWrite, carryOut, zeroOut, carryWrite, zeroWrite;
  logic queueWrite, pointerWrite;
  logic [31:0] result, queueOut;
  int fails = 0, num_checks = 0, cycles = 0;
  always #50 mclk = ~mclk;
  cmla_math_logic_alu i_cmla_math_logic_alu (.mclk(mclk), .srst(srst), .clkEn(clkEn),
    .opValid(opValid), .opCode(opCode), .dstIn(dstIn), .srcIn(srcIn),
    .singleOperand(singleOperand), .carryIn(carryIn), .zeroIn(zeroIn),
    .carryWriteFlag(carryWriteFlag), .zeroWriteFlag(zeroWriteFlag),
    .queuePrefixSet(queuePrefixSet), .queueIn(queueIn), .randomBits(randomBits),
    .extractIndex(extractIndex), .programCounter(programCounter), .relativeBit(relativeBit),
    .forceAbsolute(forceAbsolute), .pointerSel(pointerSel), .resultValid(resultValid),
    .result(result), .resultWrite(resultWrite), .carryOut(carryOut), .zeroOut(zeroOut),
    .carryWrite(carryWrite), .zeroWrite(zeroWrite), .queueOut(queueOut),
    .queueWrite(queueWrite), .pointerWrite(pointerWrite), .pointerIndex(pointerIndex));
  cmla_core_model i_cmla_core_model (.mclk(mclk), .srst(srst), .presetEn(presetEn),
    .presetCarry(presetCarry), .presetZero(presetZero), .carryWrite(carryWrite),
    .zeroWrite(zeroWrite), .carryOut(carryOut), .zeroOut(zeroOut), .flagCarry(carryIn),
    .flagZero(zeroIn));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end
  // cz and ecz are {carry, zero}; flags are preset one cycle ahead through the core model
  task automatic run_op(input cmla_op_t op, input logic [31:0] d, s, input logic [1:0] cz,
                        input logic wf, wr, input logic [31:0] er, input logic [1:0] ecz);
    @(posedge mclk); #1;
    {presetEn, presetCarry, presetZero} = {1'h1, cz};
    @(posedge mclk); #1;
    presetEn = 1'h0;
    opValid = 1'h1;
    opCode = op;
    dstIn = d;
    srcIn = s;
    {carryWriteFlag, zeroWriteFlag} = {wf, wf};
    @(posedge mclk); #1;
    opValid = 1'h0;
    // the take edge has passed: the answer lands on the next enabled edge
    `CHK(resultValid, 1'h0)
    @(posedge mclk); #1;
    `CHK(resultValid, 1'h1)
    `CHK(resultWrite, wr)
    if (wr) `CHK(result, er)
    `CHK({carryWrite, zeroWrite}, {wf, wf})
    if (wf) `CHK({carryOut, zeroOut}, ecz)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_sums();
    singleOperand = 1'h1;
    run_op(CMLA_MAGNITUDE_OP, 32'hFFFF_FFFB, 32'h0, 2'h0, 1, 1, 32'h5, 2'h2);
    singleOperand = 1'h0;
    run_op(CMLA_MAGNITUDE_OP, 32'h0, 32'h0000_0007, 2'h0, 1, 1, 32'h7, 2'h0);
    run_op(CMLA_SUM_OP, 32'hFFFF_FFFF, 32'h1, 2'h0, 1, 1, 32'h0, 2'h3);
    run_op(CMLA_SIGNED_SUM_OP, 32'h7FFF_FFFF, 32'h1, 2'h0, 1, 1, 32'h8000_0000, 2'h0);
    run_op(CMLA_EXTENDED_SUM_OP, 32'hFFFF_FFFF, 32'h0, 2'h2, 1, 1, 32'h0, 2'h2);
    run_op(CMLA_SIGNED_EXTENDED_SUM_OP, 32'h1, 32'hFFFF_FFFE, 2'h3, 1, 1, 32'h0, 2'h1);
    // the written flags must reach the core's flag registers one edge later
    @(posedge mclk); #1;
    `CHK({carryIn, zeroIn}, 2'h1)
  endtask
  task automatic t_masks();
    run_op(CMLA_MASK_KEEP_OP, 32'h0000_0F0F, 32'h0000_00FF, 2'h0, 1, 1, 32'hF, 2'h0);
    run_op(CMLA_MASK_CLEAR_OP, 32'h0000_0007, 32'h0000_0000, 2'h0, 1, 1, 32'h7, 2'h2);
  endtask
  task automatic t_fields();
    cmla_op_t fop[8] = '{CMLA_FIELD_FROM_CARRY, CMLA_FIELD_SET_HIGH, CMLA_FIELD_SET_LOW,
      CMLA_FIELD_FROM_INV_CARRY, CMLA_FIELD_TOGGLE, CMLA_FIELD_FROM_INV_ZERO,
      CMLA_FIELD_RANDOM, CMLA_FIELD_FROM_ZERO};
    logic [31:0] fexp[8] = '{32'hFC, 32'hFC, 32'hC0, 32'hC0, 32'hCC, 32'hFC, 32'hE4, 32'hC0};
    randomBits = 32'hA5A5_A5A5;
    // bits 5:2 of 0xF0, carry 1 and zero 0 so each source is told apart
    for (int i = 0; i < 8; i++) run_op(fop[i], 32'hF0, 32'h62, 2'h2, 1, 1, fexp[i], 2'h0);
    run_op(CMLA_FIELD_SET_LOW, 32'h4, 32'h2, 2'h0, 1, 1, 32'h0, 2'h3);
    {queuePrefixSet, queueIn} = {1'h1, 32'h0};
    run_op(CMLA_FIELD_SET_HIGH, 32'hF0, 32'h62, 2'h0, 1, 1, 32'hF4, 2'h0);
    queuePrefixSet = 1'h0;
  endtask
  task automatic t_compares();
    run_op(CMLA_COMPARE_OP, 32'h1, 32'h2, 2'h0, 1, 0, 32'h0, 2'h2);
    run_op(CMLA_COMPARE_OP, 32'h5, 32'h5, 2'h2, 1, 0, 32'h0, 2'h1);
    run_op(CMLA_COMPARE_REVERSE_OP, 32'h1, 32'h2, 2'h0, 1, 0, 32'h0, 2'h0);
    run_op(CMLA_COMPARE_MSB_OP, 32'h0, 32'h1, 2'h0, 1, 0, 32'h0, 2'h2);
    run_op(CMLA_COMPARE_SIGNED_OP, 32'h8000_0000, 32'h1, 2'h0, 1, 0, 32'h0, 2'h2);
    run_op(CMLA_COMPARE_EXTENDED_OP, 32'h5, 32'h4, 2'h3, 1, 0, 32'h0, 2'h1);
    run_op(CMLA_COMPARE_SIGNED_EXTENDED_OP, 32'h0, 32'hFFFF_FFFF, 2'h2, 1, 0, 0, 2'h0);
    run_op(CMLA_CONDITIONAL_SUBTRACT_OP, 32'h5, 32'h5, 2'h0, 1, 1, 32'h0, 2'h3);
    run_op(CMLA_CONDITIONAL_SUBTRACT_OP, 32'h4, 32'h5, 2'h2, 1, 1, 32'h4, 2'h0);
  endtask
  function automatic logic [31:0] crc_ref(input logic [31:0] d, p, input logic [3:0] b);
    for (int i = 3; i >= 0; i--) d = (d[0] ^ b[i]) ? ((d >> 1) ^ p) : (d >> 1);
    return d;
  endfunction
  task automatic t_crc();
    run_op(CMLA_CRC_BIT_STEP, 32'h1, 32'hEDB8_8320, 2'h0, 0, 1, 32'hEDB8_8320, 2'h0);
    run_op(CMLA_CRC_BIT_STEP, 32'h1, 32'hEDB8_8320, 2'h2, 0, 1, 32'h0, 2'h0);
    queueIn = 32'hA123_4567;
    run_op(CMLA_CRC_NIBBLE_STEP, 32'h1234_5678, 32'hEDB8_8320, 2'h0, 0, 1,
           crc_ref(32'h1234_5678, 32'hEDB8_8320, 4'hA), 2'h0);
    `CHK({queueWrite, queueOut}, {1'h1, 32'h1234_5670})
  endtask
  task automatic t_mod_bits();
    run_op(CMLA_WRAP_DECREMENT, 32'h0, 32'h9, 2'h0, 1, 1, 32'h9, 2'h2);
    run_op(CMLA_WRAP_DECREMENT, 32'h3, 32'h9, 2'h2, 1, 1, 32'h2, 2'h0);
    run_op(CMLA_WRAP_INCREMENT, 32'h9, 32'h9, 2'h0, 1, 1, 32'h0, 2'h3);
    run_op(CMLA_WRAP_INCREMENT, 32'h3, 32'h9, 2'h2, 1, 1, 32'h4, 2'h0);
    run_op(CMLA_LOW_MASK_GEN, 32'h0, 32'h0, 2'h0, 0, 1, 32'h1, 2'h0);
    run_op(CMLA_ONE_HOT_DECODE, 32'h0, 32'h3F, 2'h0, 0, 1, 32'h8000_0000, 2'h0);
    run_op(CMLA_PRIORITY_ENCODE, 32'h0, 32'h0001_0001, 2'h0, 1, 1, 32'h10, 2'h2);
    run_op(CMLA_PRIORITY_ENCODE, 32'h0, 32'h0, 2'h2, 1, 1, 32'h0, 2'h1);
    singleOperand = 1'h1;
    run_op(CMLA_LOW_MASK_GEN, 32'h1F, 32'h0, 2'h0, 0, 1, 32'hFFFF_FFFF, 2'h0);
    run_op(CMLA_ONE_HOT_DECODE, 32'h4, 32'h1F, 2'h0, 0, 1, 32'h10, 2'h0);
    singleOperand = 1'h0;
  endtask
  task automatic t_force_extract();
    run_op(CMLA_FORCE_MIN_OP, 32'h3, 32'h5, 2'h0, 1, 1, 32'h5, 2'h2);
    run_op(CMLA_FORCE_MIN_OP, 32'h5, 32'h3, 2'h2, 1, 1, 32'h5, 2'h0);
    run_op(CMLA_FORCE_MIN_SIGNED_OP, 32'hFFFF_FFFF, 32'h1, 2'h0, 1, 1, 32'h1, 2'h2);
    run_op(CMLA_FORCE_MAX_OP, 32'h5, 32'h3, 2'h0, 1, 1, 32'h3, 2'h2);
    run_op(CMLA_FORCE_MAX_SIGNED_OP, 32'h1, 32'hFFFF_FFFF, 2'h0, 1, 1, 32'hFFFF_FFFF, 2'h2);
    extractIndex = 2'h2;
    run_op(CMLA_EXTRACT_BYTE, 32'hFFFF_FFFF, 32'h1122_3344, 2'h0, 0, 1, 32'h22, 2'h0);
    extractIndex = 2'h3;
    run_op(CMLA_EXTRACT_NIBBLE, 32'hFFFF_FFFF, 32'h1122_3344, 2'h0, 0, 1, 32'h3, 2'h0);
    extractIndex = 2'h1;
    run_op(CMLA_EXTRACT_WORD, 32'hFFFF_FFFF, 32'h1122_3344, 2'h0, 0, 1, 32'h1122, 2'h0);
  endtask
  task automatic t_load_address();
    logic [31:0] exp[4] = '{32'h410, 32'h10, 32'h0, 32'h0000_0010};
    // the last two cases wrap past 20 bits and then force absolute mode
    for (int i = 0; i < 4; i++) begin
      pointerSel = cmla_ptr_t'(i);
      programCounter = (i == 2) ? 32'h000F_FFFF : 32'h400;
      srcIn = (i == 2) ? 32'h1 : 32'h10;
      relativeBit = (i != 1);
      forceAbsolute = (i == 3);
      run_op(CMLA_LOAD_ADDRESS_OP, 32'h0, srcIn, 2'h0, 0, 0, 32'h0, 2'h0);
      `CHK({pointerWrite, pointerIndex, result}, {1'h1, 2'(i), exp[i]})
    end
  endtask
  // a frozen clock enable must hold the answer back, not drop it
  task automatic t_stall();
    @(posedge mclk); #1;
    opValid = 1'h1;
    opCode = CMLA_SUM_OP;
    dstIn = 32'h2;
    srcIn = 32'h3;
    {carryWriteFlag, zeroWriteFlag} = 2'h0;
    @(posedge mclk); #1;
    {opValid, clkEn} = 2'h0;
    repeat (3) @(posedge mclk);
    #1;
    `CHK(resultValid, 1'h0)
    clkEn = 1'h1;
    @(posedge mclk);
    #1;
    `CHK({resultValid, result}, {1'h1, 32'h5})
    // a second freeze must hold the pulse and its data in place
    clkEn = 1'h0;
    @(posedge mclk);
    #1;
    `CHK({resultValid, result}, {1'h1, 32'h5})
    clkEn = 1'h1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    srst = 1'h0;
    `CHK({resultValid, resultWrite, carryWrite, zeroWrite, queueWrite, pointerWrite}, 6'h00)
    t_sums();
    t_masks();
    t_fields();
    t_compares();
    t_crc();
    t_mod_bits();
    t_force_extract();
    t_load_address();
    t_stall();
    finish_test();
  end
endmodule
